// [shared/mcf_pkg.sv]
package mcf_pkg;

    // ----------------------------------------------------------------
    // Register map on the host serial port
    // ----------------------------------------------------------------
    localparam int          ADDR_W                 = 24;           // Address field of a frame
    localparam int          DATA_W                 = 32;           // Data field of a frame
    localparam int          CMD_W                  = 8;            // Command field of a frame
    localparam logic [23:0] OFS_MAIN_STATE_SELECT  = 24'h01_0604;  // Operating-mode register
    localparam logic [23:0] OFS_PASSWORD           = 24'h01_0608;  // Password entry / unlock status
    localparam logic [23:0] OFS_CONFIG             = 24'h01_060c;  // Protected configuration word
    localparam logic [31:0] MAIN_SEL_RESET         = 32'h0000_0000; // Select register after reset
    localparam logic [31:0] READ_ZERO              = 32'h0000_0000; // Unmapped or hidden read value

    // ----------------------------------------------------------------
    // Frame layout: command, address, data, most significant bit first
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_WRITE              = 8'h02;        // Register write command
    localparam logic [7:0]  CMD_READ               = 8'h03;        // Register read command
    localparam logic [5:0]  BIT_HDR_LAST           = 6'h1f;        // Last bit of command plus address
    localparam logic [5:0]  BIT_DATA_LAST          = 6'h3f;        // Last bit of data
    localparam logic [5:0]  BIT_STEP               = 6'h01;        // Bit counter increment

    // ----------------------------------------------------------------
    // Fields of the select register read value
    // ----------------------------------------------------------------
    localparam int          SEL_MODE_LSB           = 0;            // Last accepted mode code
    localparam int          SEL_STATE_LSB          = 8;            // Live main state
    localparam int          MODE_W                 = 4;            // Mode code width

    // ----------------------------------------------------------------
    // Operating-mode codes written by the host
    // ----------------------------------------------------------------
    localparam logic [3:0]  MODE_STANDBY           = 4'h0;
    localparam logic [3:0]  MODE_PROC_LINK         = 4'h1;
    localparam logic [3:0]  MODE_PROC_LINK_ALT     = 4'h2;
    localparam logic [3:0]  MODE_SYM_CIPHER        = 4'h3;
    localparam logic [3:0]  MODE_MEM_WRITE         = 4'h4;
    localparam logic [3:0]  MODE_MEM_READ          = 4'h5;
    localparam logic [3:0]  MODE_RANDOM            = 4'h6;
    localparam logic [3:0]  MODE_ROOT_SERIAL       = 4'h7;
    localparam logic [3:0]  MODE_KEY_UPDATE        = 4'h8;
    localparam logic [3:0]  MODE_ERASE             = 4'h9;
    localparam logic [3:0]  MODE_SLEEP             = 4'ha;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        state_idle,
        state_power_on_read,
        state_check_root_serial_flag,
        state_standby,
        state_processor_link,
        state_processor_link_alt,
        state_symmetric_cipher,
        state_memory_write,
        state_memory_read,
        state_random_generate,
        state_root_serial_generate,
        state_key_update,
        state_erase,
        state_sleep
    } mcf_state_t;

    typedef struct packed {
        logic sck;    // Serial clock, mode 0
        logic cs_n;   // Chip select, active low
        logic mosi;   // Host to device data
    } mcf_spi_pins_t;

    typedef struct packed {
        logic [31:0] password;   // Unlock word from nonvolatile memory
        logic [31:0] config_word; // Configuration word from nonvolatile memory
    } mcf_pon_data_t;

endpackage

// [src/mcf_main_control.sv]
module mcf_main_control
    import mcf_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire mcf_spi_pins_t spi_pins,
    input  wire logic          wake_pin,
    input  wire logic          rs_check_skip_pin,
    input  wire logic          pon_done,
    input  wire mcf_pon_data_t pon_data,
    input  wire logic          rs_check_done,
    input  wire logic          func_done,
    output logic               miso_q,
    output logic               miso_oe_n_q,
    output logic               osc_enable_q,
    output logic               func_start_q,
    output logic               cipher_enable_q,
    output logic               proc_link_q,
    output logic               init_done_q,
    output mcf_state_t         state_q,
    output logic [31:0]        config_q
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0]  sync_q;          // Synchronised pins
    logic        sck_s;           // Serial clock
    logic        cs_n_s;          // Chip select, active low
    logic        mosi_s;          // Serial data in
    logic        wake_s;          // Wake request
    logic        skip_s;          // Root serial check bypass strap

    mcf_sync #(.W(5)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .d        ({spi_pins.sck, ~spi_pins.cs_n, spi_pins.mosi, wake_pin, rs_check_skip_pin}),
        .q        (sync_q)
    );

    assign sck_s  = sync_q[4];
    assign cs_n_s = ~sync_q[3];  // Select crosses active high, so a reset synchroniser reads deselected
    assign mosi_s = sync_q[2];
    assign wake_s = sync_q[1];
    assign skip_s = sync_q[0];

    // ----------------------------------------------------------------
    // Serial slave, clock mode 0
    // ----------------------------------------------------------------
    logic        sck_prev_q;      // Last sampled serial clock
    logic [5:0]  bit_cnt_q;       // Bit position in frame
    logic [31:0] in_shift_q;      // Incoming bits
    logic [31:0] in_next;         // Shift register after this bit
    logic [31:0] hdr_q;           // Command and address of frame
    logic [31:0] out_shift_q;     // Outgoing read data
    logic        sck_rise;        // Sample edge
    logic        sck_fall;        // Launch edge
    logic        hdr_done;        // Header complete on this edge
    logic        data_done;       // Data complete on this edge
    logic        wr_strobe;       // Register write this cycle
    logic        rd_load;         // Read data captured this cycle
    logic [23:0] rd_addr;         // Address of a read
    logic [31:0] read_data;       // Read multiplexer

    // Mode 0: sample on rising, shift out on falling edge
    assign sck_rise  = sck_s & ~sck_prev_q & ~cs_n_s;
    assign sck_fall  = ~sck_s & sck_prev_q & ~cs_n_s;
    assign in_next   = {in_shift_q[30:0], mosi_s};
    assign hdr_done  = sck_rise && (bit_cnt_q == BIT_HDR_LAST);
    assign data_done = sck_rise && (bit_cnt_q == BIT_DATA_LAST);
    assign wr_strobe = data_done && (hdr_q[31:24] == CMD_WRITE);
    assign rd_load   = hdr_done && (in_next[31:24] == CMD_READ);
    assign rd_addr   = in_next[23:0];

    // Edge detector and frame position
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_q <= 1'b0;
            bit_cnt_q  <= '0;
            in_shift_q <= '0;
            hdr_q      <= '0;
        end else if (clk_en) begin
            sck_prev_q <= sck_s;
            if (cs_n_s) begin
                // Deselect aborts any partial frame
                bit_cnt_q <= '0;
            end else if (sck_rise) begin
                bit_cnt_q  <= bit_cnt_q + BIT_STEP;
                in_shift_q <= in_next;
            end
            if (hdr_done) begin
                hdr_q <= in_next;
            end
        end
    end

    // Output shifter; data line released while deselected
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_shift_q <= '0;
            miso_q      <= 1'b0;
            miso_oe_n_q <= 1'b1;
        end else if (clk_en) begin
            miso_oe_n_q <= cs_n_s;
            if (cs_n_s) begin
                out_shift_q <= '0;
                miso_q      <= 1'b0;
            end else if (rd_load) begin
                out_shift_q <= read_data;
            end else if (sck_fall) begin
                miso_q      <= out_shift_q[31];
                out_shift_q <= {out_shift_q[30:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [3:0]  mode_sel_q;      // Last accepted mode code
    logic [31:0] password_q;      // Unlock word loaded at power-on
    logic        unlocked_q;      // Password accepted
    logic        skip_q;          // Strap caught while idle or in power-on read
    logic        sel_wr;          // Write to the select register
    logic        pw_wr;           // Write to the password register
    logic        cfg_wr;          // Write to the configuration register
    logic [3:0]  mode_wr;         // Mode code being written
    logic        mode_valid;      // Code names a function
    logic        host_held;       // State left only by the host
    logic        hw_func;         // State left by hardware
    logic        sel_accept;      // Mode write honoured
    mcf_state_t  mode_target;     // State named by the code
    mcf_state_t  state_d;         // Next main state

    assign sel_wr  = wr_strobe && (hdr_q[23:0] == OFS_MAIN_STATE_SELECT);
    assign pw_wr   = wr_strobe && (hdr_q[23:0] == OFS_PASSWORD);
    assign cfg_wr  = wr_strobe && (hdr_q[23:0] == OFS_CONFIG) && unlocked_q;
    assign mode_wr = in_next[MODE_W-1:0];

    // Host-held states wait for a standby write
    assign host_held = (state_q == state_processor_link) || (state_q == state_processor_link_alt) ||
                       (state_q == state_symmetric_cipher);
    assign hw_func   = (state_q == state_memory_write) || (state_q == state_memory_read) ||
                       (state_q == state_random_generate) || (state_q == state_root_serial_generate) ||
                       (state_q == state_key_update) || (state_q == state_erase);

    // Mode code decode; unknown codes are ignored
    assign mode_valid  = (mode_wr != MODE_STANDBY) && (mode_wr <= MODE_SLEEP);
    assign mode_target = (mode_wr == MODE_PROC_LINK)     ? state_processor_link :
                         (mode_wr == MODE_PROC_LINK_ALT) ? state_processor_link_alt :
                         (mode_wr == MODE_SYM_CIPHER)    ? state_symmetric_cipher :
                         (mode_wr == MODE_MEM_WRITE)     ? state_memory_write :
                         (mode_wr == MODE_MEM_READ)      ? state_memory_read :
                         (mode_wr == MODE_RANDOM)        ? state_random_generate :
                         (mode_wr == MODE_ROOT_SERIAL)   ? state_root_serial_generate :
                         (mode_wr == MODE_KEY_UPDATE)    ? state_key_update :
                         (mode_wr == MODE_ERASE)         ? state_erase :
                         (mode_wr == MODE_SLEEP)         ? state_sleep : state_standby;

    // Only standby takes a function; host-held states take standby
    assign sel_accept = sel_wr && (((state_q == state_standby) && mode_valid) ||
                                   (host_held && (mode_wr == MODE_STANDBY)));

    // Read multiplexer; configuration hidden while locked
    assign read_data = (rd_addr == OFS_MAIN_STATE_SELECT) ?
                           {20'h0_0000, state_q, 4'h0, mode_sel_q} :
                       (rd_addr == OFS_PASSWORD) ? {31'h0000_0000, unlocked_q} :
                       ((rd_addr == OFS_CONFIG) && unlocked_q) ? config_q : READ_ZERO;

    // Register storage and power-on load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_sel_q <= MAIN_SEL_RESET[MODE_W-1:0];
            password_q <= '0;
            config_q   <= '0;
            unlocked_q <= 1'b0;
            skip_q     <= 1'b0;
        end else if (clk_en) begin
            if (sel_accept) begin
                mode_sel_q <= mode_wr;
            end
            if ((state_q == state_power_on_read) && pon_done) begin
                // Values come from nonvolatile memory, no host action
                password_q <= pon_data.password;
                config_q   <= pon_data.config_word;
                unlocked_q <= 1'b0;
            end else if (pw_wr) begin
                // A wrong word relocks, so guessing gains nothing
                unlocked_q <= (in_next == password_q);
            end else if (cfg_wr) begin
                config_q <= in_next;
            end
            if ((state_q == state_idle) || (state_q == state_power_on_read)) begin
                // Strap tracked until power-on read ends; its synchroniser needs two cycles after reset
                skip_q <= skip_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // Main state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            state_idle: begin
                state_d = state_power_on_read;
            end
            state_power_on_read: begin
                if (pon_done) begin
                    state_d = skip_q ? state_standby : state_check_root_serial_flag;
                end
            end
            state_check_root_serial_flag: begin
                if (rs_check_done) begin
                    state_d = state_standby;
                end
            end
            state_standby: begin
                if (sel_accept) begin
                    state_d = mode_target;
                end
            end
            state_processor_link, state_processor_link_alt, state_symmetric_cipher: begin
                if (sel_accept) begin
                    state_d = state_standby;
                end
            end
            state_memory_write, state_memory_read, state_random_generate,
            state_root_serial_generate, state_key_update, state_erase: begin
                if (func_done) begin
                    state_d = state_standby;
                end
            end
            state_sleep: begin
                if (wake_s) begin
                    state_d = state_idle;
                end
            end
            default: begin
                // Two spare codes recover through the initial sequence
                state_d = state_idle;
            end
        endcase
    end

    // State register and decoded controls
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= state_idle;
            osc_enable_q    <= 1'b1;
            func_start_q    <= 1'b0;
            cipher_enable_q <= 1'b0;
            proc_link_q     <= 1'b0;
            init_done_q     <= 1'b0;
        end else if (clk_en) begin
            state_q         <= state_d;
            osc_enable_q    <= (state_d != state_sleep);
            func_start_q    <= (state_d != state_q) && (state_q == state_standby) &&
                               (state_d >= state_memory_write) && (state_d <= state_erase);
            cipher_enable_q <= (state_d == state_symmetric_cipher);
            proc_link_q     <= (state_d == state_processor_link) || (state_d == state_processor_link_alt);
            if (state_d == state_idle) begin
                init_done_q <= 1'b0;
            end else if (state_d == state_standby) begin
                init_done_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_state_legal:     assert property (state_q <= state_sleep)
        else $error("main state outside the fourteen states");
    a_wake_init:       assert property (clk_en && state_q == state_sleep && wake_s |=> state_q == state_idle)
        else $error("wake did not restart initial sequence");
    a_hw_return:       assert property (clk_en && hw_func && func_done |=> state_q == state_standby)
        else $error("finished function did not return to standby");
    a_idle_to_pon:     assert property (clk_en && state_q == state_idle |=> state_q == state_power_on_read)
        else $error("idle did not advance to power-on read");
    a_skip_bypass:     assert property (clk_en && state_q == state_power_on_read && pon_done && skip_q
                                        |=> state_q == state_standby && init_done_q)
        else $error("bypass strap did not skip flag check");
    a_pon_load:        assert property (clk_en && state_q == state_power_on_read && pon_done
                                        |=> config_q == $past(pon_data.config_word))
        else $error("initial values not loaded");
    a_link_by_host:    assert property (state_q == state_processor_link && $past(state_q) != state_processor_link
                                        |-> $past(sel_accept))
        else $error("processor link entered without host write");
    a_cipher_by_host:  assert property (state_q == state_symmetric_cipher && $past(state_q) != state_symmetric_cipher
                                        |-> $past(sel_accept) && cipher_enable_q)
        else $error("cipher state entered without host write");
    a_sleep_osc_off:   assert property (state_q == state_sleep |-> !osc_enable_q)
        else $error("oscillator left running in sleep");
    a_miso_released:   assert property (clk_en && cs_n_s |=> miso_oe_n_q && !miso_q)
        else $error("data line driven while deselected");
    a_locked_hidden:   assert property (clk_en && rd_load && rd_addr == OFS_CONFIG && !unlocked_q
                                        |=> out_shift_q == READ_ZERO)
        else $error("configuration readable while locked");
    a_midfunc_ignored: assert property (clk_en && hw_func && sel_wr && !func_done
                                        |=> state_q == $past(state_q))
        else $error("mode write honoured during a function");

    c_init_done:     cover property (state_q == state_check_root_serial_flag ##[1:20] state_q == state_standby);
    c_cipher_round:  cover property (state_q == state_symmetric_cipher ##[1:200] state_q == state_standby);
    c_func_round:    cover property (func_start_q ##[1:50] state_q == state_standby);
    c_unlock:        cover property (!unlocked_q ##1 unlocked_q);

endmodule

// [src/mcf_sync.sv]
module mcf_sync
    import mcf_pkg::*;
#(
    parameter int W = 1  // Number of independent bits
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    logic [W-1:0] meta_q;  // First stage, read only by q

    // First stage feeds the second and nothing else
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else if (clk_en) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// [tb/mcf_host_model.sv]
// Host microcontroller acting as serial master in clock mode 0
module mcf_host_model
    import mcf_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    miso_q,
    output mcf_spi_pins_t spi_pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle: deselected, clock low
    initial spi_pins = '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};

    // One whole 64-bit frame, MSB first; read data sampled on each rise of the 32 data bits
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
        logic [63:0] frm;
        frm = {cmd, adr, dat};
        rd = '0;
        @(posedge core_clk) #10 spi_pins.cs_n = 1'b0;
        for (int i = 63; i >= 0; i--) begin
            spi_pins.mosi = frm[i];                  // Data set while sck low
            repeat (5) @(posedge core_clk);
            #10 spi_pins.sck = 1'b1;
            if (i < 32) rd = {rd[30:0], miso_q};
            repeat (5) @(posedge core_clk);
            #10 spi_pins.sck = 1'b0;
        end
        repeat (5) @(posedge core_clk);
        #10 spi_pins.cs_n = 1'b1;
        spi_pins.mosi = ~spi_pins.mosi;              // Released line shows no stale value
        repeat (4) @(posedge core_clk);              // Gap between frames
    endtask
endmodule

// [tb/tb.sv]
module tb;
    import mcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic [3:0] mode; mcf_state_t st; logic hw; } mcf_row_t;
    logic          core_clk, rst_n, wake_pin, skip_pin, chk_done, func_done, pon_done;
    logic          miso_q, oe_n, osc_en, start, cip_en, link, init_done;
    mcf_state_t    state_q;
    logic [31:0]   config_q, rd;
    mcf_spi_pins_t pins;
    int            failures = 0, checked = 0, starts = 0, saw_chk = 0, drv = 0;
    // Mode code, state it should reach, finished by hardware
    mcf_row_t      rows [9] = '{'{MODE_SYM_CIPHER, state_symmetric_cipher, 1'b0},
        '{MODE_PROC_LINK, state_processor_link, 1'b0}, '{MODE_PROC_LINK_ALT, state_processor_link_alt, 1'b0},
        '{MODE_MEM_WRITE, state_memory_write, 1'b1}, '{MODE_MEM_READ, state_memory_read, 1'b1},
        '{MODE_RANDOM, state_random_generate, 1'b1}, '{MODE_ROOT_SERIAL, state_root_serial_generate, 1'b1},
        '{MODE_KEY_UPDATE, state_key_update, 1'b1}, '{MODE_ERASE, state_erase, 1'b1}};

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Count start pulses, cycles in the flag check and cycles with the data line driven
    always @(posedge core_clk) begin
        if (func_start_seen()) starts++;
        if (oe_n === 1'b0) drv++;
        if (state_q === state_check_root_serial_flag) saw_chk++;
    end
    function automatic bit func_start_seen();
        return start === 1'b1;
    endfunction

    mcf_main_control u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .spi_pins(pins),
        .wake_pin(wake_pin), .rs_check_skip_pin(skip_pin), .pon_done(pon_done),
        .pon_data('{password: 32'h0000_a5a5, config_word: 32'h0000_0c3f}), .rs_check_done(chk_done),
        .func_done(func_done), .miso_q(miso_q), .miso_oe_n_q(oe_n), .osc_enable_q(osc_en),
        .func_start_q(start), .cipher_enable_q(cip_en), .proc_link_q(link), .init_done_q(init_done),
        .state_q(state_q), .config_q(config_q));
    mcf_host_model u_host (.core_clk(core_clk), .miso_q(miso_q), .spi_pins(pins));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait for a main state
    task automatic wait_st(input mcf_state_t s);
        for (int n = 0; n < 300 && state_q !== s; n++) @(posedge core_clk);
        chk("state", 32'(s), 32'(state_q));
        if (state_q !== s) stop_test();
    endtask
    task automatic wr(input logic [3:0] m);
        u_host.xfer(CMD_WRITE, OFS_MAIN_STATE_SELECT, {28'h0, m}, rd);
    endtask
    task automatic done_pulse();
        @(posedge core_clk) #10 func_done = 1'b1;
        @(posedge core_clk) #10 func_done = 1'b0;
    endtask

    initial begin
        {rst_n, wake_pin, skip_pin, chk_done, func_done, pon_done} = '0;
        repeat (8) @(posedge core_clk);
        #10 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        chk("pon wait", 32'(state_power_on_read), 32'(state_q));
        #10 pon_done = 1'b1;
        wait_st(state_check_root_serial_flag);
        @(posedge core_clk) #10 chk_done = 1'b1;
        @(posedge core_clk) #10 chk_done = 1'b0;
        wait_st(state_standby);
        chk("init_done", 32'h1, {31'h0, init_done});
        chk("config_q", 32'h0000_0c3f, config_q);
        $display("test init done");
        foreach (rows[i]) begin
            wr(rows[i].mode);
            chk("mode state", 32'(rows[i].st), 32'(state_q));
            chk("cipher", {31'h0, rows[i].st == state_symmetric_cipher}, {31'h0, cip_en});
            chk("link", {31'h0, rows[i].st inside {state_processor_link, state_processor_link_alt}},
                {31'h0, link});
            if (rows[i].hw) done_pulse();
            else wr(MODE_STANDBY);
            wait_st(state_standby);
            $display("test row %0d done", i);
        end
        chk("starts", 32'd6, 32'(starts));
        // Mode write in mid-function is ignored
        wr(MODE_MEM_WRITE);
        wr(MODE_SYM_CIPHER);
        chk("busy", 32'(state_memory_write), 32'(state_q));
        u_host.xfer(CMD_READ, OFS_MAIN_STATE_SELECT, '0, rd);
        chk("select", {20'h0, 4'(state_memory_write), 4'h0, MODE_MEM_WRITE}, rd);
        done_pulse();
        wait_st(state_standby);
        wr(4'hb);
        chk("bad code", 32'(state_standby), 32'(state_q));
        $display("test busy done");
        // Locked configuration hidden, then unlocked by password
        u_host.xfer(CMD_READ, OFS_CONFIG, '0, rd);
        chk("locked", READ_ZERO, rd);
        u_host.xfer(CMD_WRITE, OFS_PASSWORD, 32'h0000_a5a5, rd);
        u_host.xfer(CMD_READ, OFS_CONFIG, '0, rd);
        chk("unlocked", 32'h0000_0c3f, rd);
        chk("drive", 32'h1, 32'(drv != 0));
        $display("test password done");
        // Sleep, then wake with the flag check bypassed
        wr(MODE_SLEEP);
        chk("osc sleep", 32'h0, {31'h0, osc_en});
        #10 skip_pin = 1'b1;
        saw_chk = 0;
        @(posedge core_clk) #10 wake_pin = 1'b1;
        wait_st(state_standby);
        #10 wake_pin = 1'b0;
        chk("flag check seen", 32'h0, 32'(saw_chk));
        chk("osc awake", 32'h1, {31'h0, osc_en});
        $display("test sleep done");
        // Reset in mid-run, strap high, slow power-on read
        @(posedge core_clk) #10 rst_n = 1'b0;
        pon_done = 1'b0;
        @(posedge core_clk) #10 saw_chk = 0;
        chk("reset state", 32'(state_idle), 32'(state_q));
        chk("reset flags", 32'h30, {26'h0, osc_en, oe_n, init_done, start, cip_en, link});
        chk("reset config", 32'h0, config_q);
        repeat (2) @(posedge core_clk);
        #10 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #10 pon_done = 1'b1;
        wait_st(state_standby);
        chk("strap after reset", 32'h0, 32'(saw_chk));
        chk("oe_n idle", 32'h1, {31'h0, oe_n});
        $display("test reset done");
        stop_test();
    end
endmodule
